// ===== design/int_vector_pkg.sv
// Constants, types and vector map for the interrupt vectoring block
`default_nettype none
package int_vector_pkg;
   // ==========================================================
   // Vector map
   localparam int         VEC_COUNT     = 32;
   localparam logic [4:0] VEC_RESET     = 5'h00;
   localparam logic [4:0] VEC_SWI       = 5'h01;
   localparam logic [4:0] VEC_LVD       = 5'h02;
   localparam logic [4:0] VEC_EXT_PIN   = 5'h03;
   localparam logic [4:0] VEC_KEYPAD    = 5'h12;
   localparam logic [4:0] VEC_CONVERTER = 5'h13;
   localparam logic [4:0] VEC_PERIODIC  = 5'h17;
   localparam logic [15:0] VEC_TOP_ADDR = 16'hFFFE;
   // ==========================================================
   // Sequence lengths and reset values
   localparam logic [2:0] PUSH_BYTES    = 3'h5;
   localparam logic [2:0] POP_BYTES     = 3'h5;
   localparam logic [2:0] FILL_BYTES    = 3'h3;
   localparam logic [2:0] VEC_BYTES     = 3'h2;
   localparam int         CCR_MASK_BIT  = 3;
   localparam logic [15:0] SP_RESET     = 16'h00FF;
   localparam logic       MASK_RESET    = 1'b1;
   // ==========================================================
   // Types
   typedef enum logic [2:0] {ST_IDLE, ST_PUSH, ST_VEC, ST_POP, ST_FILL} seq_state_t;
   typedef struct packed {
      logic [15:0] prog_counter;
      logic [7:0]  idx_low;
      logic [7:0]  acc;
      logic [7:0]  condition_code_reg;
   } cpu_regs_t;
   typedef struct packed {
      logic periodic_int_flag;
      logic periodic_int_enable;
      logic conversion_complete_flag;
      logic converter_int_enable;
      logic keypad_flag;
      logic keypad_int_enable;
      logic lvd_flag;
      logic lvd_int_enable;
   } periph_src_t;
   typedef struct packed {
      logic       req;
      logic       we;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } mem_cmd_t;
endpackage
`default_nettype wire

// ===== design/int_vector_ctrl.sv
// Interrupt stacking, vector fetch, priority and external pin detector
`default_nettype none
// What this block does
// RL1 - Entry pushes low PC, high PC, index low, accumulator, condition codes at free byte.
// RL2 - After five pushes the stack pointer sits one below the condition code byte.
// RL3 - Stacked PC is the next main-program instruction address supplied by the core.
// RL4 - High index byte is never stacked or restored automatically.
// RL5 - Return pops condition codes first, program counter last, reverse of push.
// RL6 - Return refills the pipeline with three bytes from the restored PC.
// RL7 - Handler software clears the causing flag before returning.
// RL8 - Enabled pin is sampled by clocked logic, edge-only or edge-and-level.
// RL9 - In stop an enabled asserted pin reaches wake through an unclocked path.
// RL10 - Pin detects events only while its pin-enable bit is 1.
// RL11 - Software picks polarity, detect mode, and interrupt versus poll-only.
// RL12 - Pull-disable 0 enables pullup or pulldown by polarity; 1 turns it off.
// RL13 - Flag sets on assertion edge; level mode holds it while pin asserted.
// RL14 - Pin level is offered to branch-on-pin instructions while pin is enabled.
// RL15 - Vector high byte at lower address, low byte at next address.
// RL16 - Lower vector number wins when several requests are pending.
// RL17 - Source flag requests the core only while its local enable is 1.
// RL18 - With mask clear: stack, set mask, then fetch highest-priority vector.
// RL19 - Vectors 24-31 unused; 23 periodic, 19 converter, 18 keypad.
// RL20 - Vector 0 reset, 1 software interrupt, 2 low voltage, 3 external pin.
// RL21 - Reset sets the global mask bit.
// RL22 - Writing the acknowledge bit clears the pin flag, nothing else.
// RL23 - Priority is combinational and sampled at the instruction boundary.
module int_vector_ctrl
   import int_vector_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // Core side
   input  wire logic        insn_boundary,
   input  wire logic        swi_req,
   input  wire logic        rti_req,
   input  wire logic        mask_set_req,
   input  wire logic        mask_clear_req,
   input  wire cpu_regs_t   regs_in,
   input  wire logic [15:0] sp_in,
   input  wire logic        sp_load,
   output var  cpu_regs_t   regs_out,
   output var  logic [15:0] stack_pointer,
   output var  logic [23:0] prefetch,
   output var  logic        global_mask,
   output var  logic [4:0]  taken_vector,
   output logic             seq_busy,
   output var  logic        seq_done,
   output logic             irq_pending,
   // Memory port, read data valid the cycle after a read request
   output mem_cmd_t         mem_cmd,
   input  wire logic [7:0]  mem_rdata,
   // Peripheral sources
   input  wire periph_src_t periph,
   // External interrupt pin
   input  wire logic        ext_pin_in,
   input  wire logic        stop_mode,
   input  wire logic        ext_int_pin_enable,
   input  wire logic        ext_int_polarity_select,
   input  wire logic        ext_int_detect_mode,
   input  wire logic        ext_int_int_enable,
   input  wire logic        ext_int_pull_disable,
   input  wire logic        ext_int_ack,
   output var  logic        ext_int_flag,
   output logic             pull_up_en,
   output logic             pull_down_en,
   output logic             pin_level,
   output logic             wake_async
);
   // ==========================================================
   // External pin detector
   logic ext_asserted;
   logic ext_edge;
   logic ext_prev_reg;
   logic flag_next;

   // Polarity 1 means rising edge / high level is the asserted state
   assign ext_asserted = ext_int_pin_enable & (ext_pin_in == ext_int_polarity_select);   // RL10 RL11
   assign ext_edge     = ext_asserted & ~ext_prev_reg;                                   // RL13
   // Set wins over acknowledge; level mode keeps re-setting while held
   assign flag_next    = ext_edge | (ext_int_detect_mode & ext_asserted)                 // RL8 RL13
                       | (ext_int_flag & ~ext_int_ack);                                  // RL22
   // Pull device follows polarity only while pin function is on
   assign pull_up_en   = ext_int_pin_enable & ~ext_int_pull_disable & ~ext_int_polarity_select; // RL12
   assign pull_down_en = ext_int_pin_enable & ~ext_int_pull_disable & ext_int_polarity_select;  // RL12
   assign pin_level    = ext_int_pin_enable & ext_pin_in;                                // RL14
   // Unclocked path: no flop in the way since the clock is halted in stop
   assign wake_async   = stop_mode & ext_asserted;                                       // RL9

   // Edge history and sticky flag
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         ext_prev_reg <= 1'b0;
         ext_int_flag <= 1'b0;
      end else begin
         ext_prev_reg <= ext_asserted;
         ext_int_flag <= flag_next;   // RL8
      end
   end

   // ==========================================================
   // Request qualification and priority
   logic [VEC_COUNT-1:0] req_vec;
   logic [4:0]           win_vec;
   logic                 maskable_pending;

   // Each source request is its flag gated by the local enable; the software interrupt request is not gated
   always_comb begin
      req_vec                = '0;
      req_vec[VEC_SWI]       = swi_req;                                              // RL20
      req_vec[VEC_LVD]       = periph.lvd_flag & periph.lvd_int_enable;              // RL20
      req_vec[VEC_EXT_PIN]   = ext_int_flag & ext_int_int_enable;                    // RL11 RL17
      req_vec[VEC_KEYPAD]    = periph.keypad_flag & periph.keypad_int_enable;        // RL19
      req_vec[VEC_CONVERTER] = periph.conversion_complete_flag
                             & periph.converter_int_enable;                          // RL19
      req_vec[VEC_PERIODIC]  = periph.periodic_int_flag & periph.periodic_int_enable; // RL17 RL19
   end

   // Lowest number wins; scan from the top so the last hit is the lowest
   always_comb begin
      win_vec = VEC_PERIODIC;
      for (int i = VEC_COUNT - 1; i >= 0; i--) begin
         if (req_vec[i]) begin
            win_vec = 5'(i);   // RL16 RL23
         end
      end
   end

   assign maskable_pending = |(req_vec & ~(32'h1 << VEC_SWI));
   assign irq_pending      = swi_req | (maskable_pending & ~global_mask);   // RL18

   // ==========================================================
   // Stacking, vector fetch, unstacking and refill sequencer
   seq_state_t  state_reg;
   seq_state_t  state_next;
   logic [2:0]  cnt_reg;
   logic        phase_reg;
   logic        take_irq;
   logic        take_rti;
   logic [7:0]  push_byte;
   logic [15:0] vec_addr;
   logic        last_push;
   logic        rd_capture;

   assign take_irq  = (state_reg == ST_IDLE) & insn_boundary & irq_pending;    // RL23
   assign take_rti  = (state_reg == ST_IDLE) & insn_boundary & rti_req & ~take_irq;
   assign last_push = (state_reg == ST_PUSH) & (cnt_reg == PUSH_BYTES - 3'h1);
   assign rd_capture = phase_reg;
   assign seq_busy  = (state_reg != ST_IDLE);
   // High byte at the lower address, two bytes per vector
   assign vec_addr  = VEC_TOP_ADDR - {10'h000, taken_vector, 1'b0} + {15'h0000, cnt_reg[0]};  // RL15

   // Push order: low PC, high PC, index low, accumulator, condition codes
   always_comb begin
      case (cnt_reg)
         3'h0:    push_byte = regs_out.prog_counter[7:0];    // RL1 RL3
         3'h1:    push_byte = regs_out.prog_counter[15:8];   // RL1
         3'h2:    push_byte = regs_out.idx_low;              // RL1 RL4
         3'h3:    push_byte = regs_out.acc;                  // RL1
         default: push_byte = regs_out.condition_code_reg;   // RL1
      endcase
   end

   // Memory commands; reads issue in phase 0 and capture in phase 1
   always_comb begin
      mem_cmd = '0;
      case (state_reg)
         ST_PUSH: begin
            mem_cmd.req   = 1'b1;
            mem_cmd.we    = 1'b1;
            mem_cmd.addr  = stack_pointer;                   // RL1
            mem_cmd.wdata = push_byte;
         end
         ST_VEC: begin
            mem_cmd.req  = ~phase_reg;
            mem_cmd.addr = vec_addr;                          // RL15
         end
         ST_POP: begin
            mem_cmd.req  = ~phase_reg;
            mem_cmd.addr = stack_pointer + 16'h0001;          // RL5
         end
         ST_FILL: begin
            mem_cmd.req  = ~phase_reg;
            mem_cmd.addr = regs_out.prog_counter + {13'h0000, cnt_reg};   // RL6
         end
         default: mem_cmd = '0;
      endcase
   end

   // Next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (take_irq) begin
               state_next = ST_PUSH;
            end else if (take_rti) begin
               state_next = ST_POP;
            end
         end
         ST_PUSH: begin
            if (last_push) begin
               state_next = ST_VEC;   // RL18
            end
         end
         ST_VEC: begin
            if (rd_capture && cnt_reg == VEC_BYTES - 3'h1) begin
               state_next = ST_FILL;
            end
         end
         ST_POP: begin
            if (rd_capture && cnt_reg == POP_BYTES - 3'h1) begin
               state_next = ST_FILL;   // RL6
            end
         end
         ST_FILL: begin
            if (rd_capture && cnt_reg == FILL_BYTES - 3'h1) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // State, byte counter and read phase
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= 3'h0;
         phase_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         phase_reg <= (state_reg inside {ST_VEC, ST_POP, ST_FILL}) & ~phase_reg & (state_next == state_reg);
         if (state_next != state_reg) begin
            cnt_reg <= 3'h0;
         end else if (state_reg == ST_PUSH || rd_capture) begin
            cnt_reg <= cnt_reg + 3'h1;
         end
      end
   end

   // Stack pointer: post-decrement on push, pre-increment on pop
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         stack_pointer <= SP_RESET;
      end else if (state_reg == ST_PUSH) begin
         stack_pointer <= stack_pointer - 16'h0001;   // RL2
      end else if (state_reg == ST_POP && rd_capture) begin
         stack_pointer <= stack_pointer + 16'h0001;   // RL5
      end else if (state_reg == ST_IDLE && sp_load) begin
         stack_pointer <= sp_in;
      end
   end

   // Global mask: set at reset and on entry, restored from popped codes
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         global_mask <= MASK_RESET;   // RL21
      end else if (last_push || mask_set_req) begin
         global_mask <= 1'b1;         // RL18
      end else if (state_reg == ST_POP && rd_capture && cnt_reg == 3'h0) begin
         global_mask <= mem_rdata[CCR_MASK_BIT];
      end else if (mask_clear_req && state_reg == ST_IDLE) begin
         global_mask <= 1'b0;
      end
   end

   // Register image: captured at entry, rebuilt by pops and vector fetch
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         regs_out     <= '0;
         taken_vector <= VEC_RESET;
      end else if (take_irq) begin
         regs_out     <= regs_in;    // RL3
         taken_vector <= win_vec;    // RL18 RL23
      end else if (take_rti) begin
         regs_out     <= regs_in;    // RL4
      end else if (last_push) begin
         regs_out.condition_code_reg[CCR_MASK_BIT] <= 1'b1;
      end else if (rd_capture && state_reg == ST_VEC) begin
         if (cnt_reg == 3'h0) begin
            regs_out.prog_counter[15:8] <= mem_rdata;   // RL15
         end else begin
            regs_out.prog_counter[7:0]  <= mem_rdata;   // RL15
         end
      end else if (rd_capture && state_reg == ST_POP) begin
         case (cnt_reg)
            3'h0:    regs_out.condition_code_reg <= mem_rdata;   // RL5
            3'h1:    regs_out.acc                <= mem_rdata;
            3'h2:    regs_out.idx_low            <= mem_rdata;
            3'h3:    regs_out.prog_counter[15:8] <= mem_rdata;
            default: regs_out.prog_counter[7:0]  <= mem_rdata;   // RL5
         endcase
      end
   end

   // Prefetch queue and completion pulse
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         prefetch <= '0;
         seq_done <= 1'b0;
      end else begin
         seq_done <= (state_reg == ST_FILL) & rd_capture & (cnt_reg == FILL_BYTES - 3'h1);
         if (state_reg == ST_FILL && rd_capture) begin
            prefetch <= {prefetch[15:0], mem_rdata};   // RL6
         end
      end
   end

   // ==========================================================
   // Assertions
   a_mask_after_reset: assert property (@(posedge clock) $fell(sys_rst) |-> global_mask)   // RL21
      else $error("mask not set after reset");
   a_push_sp_five: assert property (@(posedge clock) disable iff (sys_rst)   // RL2
      take_irq |=> ##5 (stack_pointer == $past(stack_pointer, 5) - 16'h0005))
      else $error("stack pointer not five below after pushes");
   a_push_first_pcl: assert property (@(posedge clock) disable iff (sys_rst)   // RL1
      take_irq |=> (mem_cmd.we && mem_cmd.addr == $past(stack_pointer)
                    && mem_cmd.wdata == $past(regs_in.prog_counter[7:0])))
      else $error("first push not low program counter at free byte");
   a_push_ccr_last: assert property (@(posedge clock) disable iff (sys_rst)   // RL1
      take_irq |=> ##4 (mem_cmd.we && mem_cmd.addr == $past(stack_pointer, 5) - 16'h0004
                        && mem_cmd.wdata == $past(regs_in.condition_code_reg, 5)))
      else $error("fifth push not condition codes");
   a_mask_on_entry: assert property (@(posedge clock) disable iff (sys_rst)   // RL18
      take_irq |=> ##5 (global_mask && state_reg == ST_VEC))
      else $error("mask not set before vector fetch");
   a_vec_hi_addr: assert property (@(posedge clock) disable iff (sys_rst)   // RL15
      (state_reg == ST_VEC && !phase_reg && cnt_reg == 3'h0) |->
      mem_cmd.addr == VEC_TOP_ADDR - {10'h000, taken_vector, 1'b0})
      else $error("vector high byte address wrong");
   a_pin_disabled: assert property (@(posedge clock) disable iff (sys_rst)   // RL10
      (!ext_int_pin_enable && !ext_int_flag) |=> !ext_int_flag)
      else $error("flag set with pin disabled");
   a_level_holds: assert property (@(posedge clock) disable iff (sys_rst)   // RL13
      (ext_int_detect_mode && ext_asserted) |=> ext_int_flag)
      else $error("flag cleared while level asserted");
   a_ack_clears: assert property (@(posedge clock) disable iff (sys_rst)   // RL22
      (ext_int_ack && !ext_asserted) |=> !ext_int_flag)
      else $error("acknowledge did not clear flag");
   a_prio_lowest: assert property (@(posedge clock) disable iff (sys_rst)   // RL16
      (req_vec[VEC_KEYPAD] && req_vec[VEC_PERIODIC]) |-> win_vec != VEC_PERIODIC)
      else $error("lower priority vector won");
   a_masked_held: assert property (@(posedge clock) disable iff (sys_rst)   // RL18
      (global_mask && !swi_req) |-> !take_irq)
      else $error("interrupt taken while masked");
   a_pull_off: assert property (@(posedge clock) disable iff (sys_rst)   // RL12
      ext_int_pull_disable |-> !(pull_up_en || pull_down_en))
      else $error("pull active while disabled");

   c_irq_entry: cover property (@(posedge clock) disable iff (sys_rst) take_irq ##[1:20] seq_done);
   c_rti_return: cover property (@(posedge clock) disable iff (sys_rst) take_rti ##[1:20] seq_done);
   c_ext_edge: cover property (@(posedge clock) disable iff (sys_rst) ext_edge && !ext_int_detect_mode);
   c_stop_wake: cover property (@(posedge clock) disable iff (sys_rst) wake_async);
endmodule
`default_nettype wire

// ===== verif/core_mem_model.sv
// Memory behind the block's bus port: stack RAM, vector table and program bytes
`default_nettype none
module core_mem_model
   import int_vector_pkg::*;
(
   input  wire logic       clock,
   input  wire mem_cmd_t   mem_cmd,
   output var  logic [7:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:65535];
   // ==========================================================
   // Contents: a known pattern so program fetches can be predicted
   initial begin
      for (int i = 0; i < 65536; i++) begin
         mem[i] = i[7:0] ^ i[15:8];
      end
   end
   // Read data is valid only in the cycle after the request; otherwise the
   // bus shows the inverse of its last value so data held one cycle too long looks wrong
   always @(posedge clock) begin
      if (mem_cmd.req && !mem_cmd.we) begin
         mem_rdata <= mem[mem_cmd.addr];
      end else begin
         mem_rdata <= ~mem_rdata;
      end
      if (mem_cmd.req && mem_cmd.we) begin
         mem[mem_cmd.addr] <= mem_cmd.wdata;
      end
   end
   // Back door for the bench to place vectors and sentinels
   task automatic put(input logic [15:0] a, input logic [7:0] d);
      mem[a] = d;
   endtask
endmodule
`default_nettype wire

// ===== verif/interrupt_vectoring_and_ext_pin_tb.sv
// Self-checking bench for interrupt stacking, vectoring and the external pin detector
`default_nettype none
module interrupt_vectoring_and_ext_pin_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import int_vector_pkg::*;
   logic        clock, sys_rst, insn_boundary, swi_req, rti_req, mask_set_req, mask_clear_req, sp_load;
   cpu_regs_t   regs_in, regs_out;
   logic [15:0] sp_in, stack_pointer;
   logic [23:0] prefetch;
   logic [4:0]  taken_vector;
   logic        global_mask, seq_busy, seq_done, irq_pending;
   mem_cmd_t    mem_cmd;
   logic [7:0]  mem_rdata;
   periph_src_t periph;
   logic        ext_pin_in, stop_mode, ext_int_pin_enable, ext_int_polarity_select, ext_int_detect_mode;
   logic        ext_int_int_enable, ext_int_pull_disable, ext_int_ack, ext_int_flag;
   logic        pull_up_en, pull_down_en, pin_level, wake_async;
   int          err_total, compares;
   logic [4:0]  vec_list [4] = '{5'h02, 5'h12, 5'h13, 5'h17};

   int_vector_ctrl int_vector_ctrl_i (.clock, .sys_rst, .insn_boundary, .swi_req, .rti_req, .mask_set_req,
      .mask_clear_req, .regs_in, .sp_in, .sp_load, .regs_out, .stack_pointer, .prefetch, .global_mask,
      .taken_vector, .seq_busy, .seq_done, .irq_pending, .mem_cmd, .mem_rdata, .periph, .ext_pin_in,
      .stop_mode, .ext_int_pin_enable, .ext_int_polarity_select, .ext_int_detect_mode, .ext_int_int_enable,
      .ext_int_pull_disable, .ext_int_ack, .ext_int_flag, .pull_up_en, .pull_down_en, .pin_level, .wake_async);
   core_mem_model core_mem_model_i (.clock, .mem_cmd, .mem_rdata);

   // ==========================================================
   // Clock and helpers
   initial clock = 1'b0;
   always #2.5 clock = ~clock;

   function automatic logic [7:0] pat(input logic [15:0] a);
      return a[7:0] ^ a[15:8];
   endfunction
   function automatic logic [23:0] fill3(input logic [15:0] a);
      return {pat(a), pat(a + 16'h0001), pat(a + 16'h0002)};
   endfunction
   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic pulse_mask(input logic set);
      mask_set_req = set;
      mask_clear_req = !set;
      cyc(1);
      mask_set_req = 1'b0;
      mask_clear_req = 1'b0;
   endtask
   task automatic pulse_ack;
      ext_int_ack = 1'b1;
      cyc(1);
      ext_int_ack = 1'b0;
   endtask
   // Offer one instruction boundary and wait, bounded, for the sequence to end
   task automatic run_seq(input logic ret, input logic swi);
      int n;
      rti_req = ret;
      swi_req = swi;
      insn_boundary = 1'b1;
      cyc(1);
      insn_boundary = 1'b0;
      rti_req = 1'b0;
      swi_req = 1'b0;
      check("busy", seq_busy, 1'b1);
      n = 0;
      while (seq_done !== 1'b1 && n < 40) begin
         cyc(1);
         n++;
      end
      check("seq_done", seq_done, 1'b1);
      check("cycles", n, ret ? 16 : 15);
      check("idle at done", seq_busy, 1'b0);
      cyc(1);
      check("done pulse", seq_done, 1'b0);
   endtask
   // Entry through vector v, with a handler address derived from v
   task automatic take(input logic [4:0] v, input logic swi);
      logic [15:0] va;
      logic [15:0] h;
      va = 16'hFFFE - {10'h000, v, 1'b0};
      h = {3'h4, v, 8'h20};
      core_mem_model_i.put(va, h[15:8]);
      core_mem_model_i.put(va + 16'h0001, h[7:0]);
      run_seq(1'b0, swi);
      check("vector", taken_vector, v);
      check("handler", regs_out.prog_counter, h);
      check("entry fill", prefetch, fill3(h));
      check("mask after entry", global_mask, 1'b1);
      check("ccr mask bit", regs_out.condition_code_reg[CCR_MASK_BIT], 1'b1);
   endtask
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // Watchdog: the tests need under 2000 cycles, so 20000 means a hang
   initial begin
      #100000;
      err_total++;
      conclude();
   end

   // ==========================================================
   // Main sequence
   initial begin
      err_total = 0;
      compares = 0;
      {sys_rst, insn_boundary, swi_req, rti_req, mask_set_req, mask_clear_req, sp_load} = 7'h40;
      regs_in = '0;
      sp_in = 16'h0000;
      periph = '0;
      {ext_pin_in, stop_mode, ext_int_pin_enable, ext_int_polarity_select} = 4'h0;
      {ext_int_detect_mode, ext_int_int_enable, ext_int_pull_disable, ext_int_ack} = 4'h0;
      cyc(20);
      sys_rst = 1'b0;
      cyc(1);
      check("sp reset", stack_pointer, 16'h00FF);
      check("mask reset", global_mask, 1'b1);
      // Stacking, priority and local enable; keypad flag raised but not enabled
      sp_in = 16'h0080;
      sp_load = 1'b1;
      cyc(1);
      sp_load = 1'b0;
      core_mem_model_i.put(16'h007B, 8'hEE);
      regs_in = '{prog_counter: 16'h1234, idx_low: 8'h56, acc: 8'h78, condition_code_reg: 8'h00};
      periph = periph_src_t'(8'hF8);
      cyc(1);
      check("masked pending", irq_pending, 1'b0);
      pulse_mask(1'b0);
      check("pending", irq_pending, 1'b1);
      take(5'h13, 1'b0);
      check("stack pcl", core_mem_model_i.mem[16'h0080], 8'h34);
      check("stack pch", core_mem_model_i.mem[16'h007F], 8'h12);
      check("stack idx", core_mem_model_i.mem[16'h007E], 8'h56);
      check("stack acc", core_mem_model_i.mem[16'h007D], 8'h78);
      check("stack ccr", core_mem_model_i.mem[16'h007C], 8'h00);
      check("sp after entry", stack_pointer, 16'h007B);
      check("below frame", core_mem_model_i.mem[16'h007B], 8'hEE);
      // Handler clears its flag before returning
      periph.conversion_complete_flag = 1'b0;
      regs_in = '0;
      run_seq(1'b1, 1'b0);
      check("regs restored", regs_out, 40'h1234567800);
      check("sp after return", stack_pointer, 16'h0080);
      check("return fill", prefetch, fill3(16'h1234));
      check("mask restored", global_mask, 1'b0);
      periph.keypad_int_enable = 1'b1;
      cyc(1);
      take(5'h12, 1'b0);
      // Each source alone through its own vector
      for (int k = 0; k < 4; k++) begin
         periph = '0;
         pulse_mask(1'b0);
         periph = periph_src_t'(8'h03 << (2 * k));
         cyc(1);
         take(vec_list[k], 1'b0);
      end
      periph = '0;
      pulse_mask(1'b0);
      pulse_mask(1'b1);
      take(5'h01, 1'b1);
      // Pin detector: disabled pin sees nothing
      ext_int_polarity_select = 1'b1;
      ext_int_int_enable = 1'b1;
      ext_pin_in = 1'b1;
      cyc(2);
      check("disabled flag", ext_int_flag, 1'b0);
      check("disabled level", pin_level, 1'b0);
      ext_pin_in = 1'b0;
      ext_int_pin_enable = 1'b1;
      cyc(1);
      check("pulldown", {pull_up_en, pull_down_en}, 2'h1);
      ext_int_pull_disable = 1'b1;
      cyc(1);
      check("pull off", {pull_up_en, pull_down_en}, 2'h0);
      ext_int_pull_disable = 1'b0;
      ext_pin_in = 1'b1;
      cyc(1);
      check("edge flag", ext_int_flag, 1'b1);
      check("pin level", pin_level, 1'b1);
      pulse_ack();
      cyc(2);
      check("edge ack", ext_int_flag, 1'b0);
      // Level mode holds the flag while the pin stays asserted
      ext_int_detect_mode = 1'b1;
      ext_pin_in = 1'b0;
      cyc(1);
      ext_pin_in = 1'b1;
      cyc(1);
      pulse_ack();
      check("level hold", ext_int_flag, 1'b1);
      ext_pin_in = 1'b0;
      pulse_ack();
      cyc(1);
      check("level ack", ext_int_flag, 1'b0);
      // Active-low polarity, wake from stop, poll-only then interrupt
      ext_int_polarity_select = 1'b0;
      ext_pin_in = 1'b1;
      stop_mode = 1'b1;
      ext_int_int_enable = 1'b0;
      cyc(1);
      check("pullup", {pull_up_en, pull_down_en}, 2'h2);
      check("no wake", wake_async, 1'b0);
      ext_pin_in = 1'b0;
      #1;
      check("wake", wake_async, 1'b1);
      cyc(1);
      stop_mode = 1'b0;
      check("low flag", ext_int_flag, 1'b1);
      pulse_mask(1'b0);
      check("poll only", irq_pending, 1'b0);
      ext_int_int_enable = 1'b1;
      cyc(1);
      check("pin request", irq_pending, 1'b1);
      take(5'h03, 1'b0);
      conclude();
   end
endmodule
`default_nettype wire
